// File: hdl/ifs_pkg.sv
package ifs_pkg;

    // ========================================================================
    // Register map (byte addresses)
    localparam logic [3:0] IFS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] IFS_ADDR_OWN = 4'h4;
    localparam logic [3:0] IFS_ADDR_STATUS = 4'h8;

    // ========================================================================
    // Field layout of the control register
    localparam int IFS_FILT_LSB = 13;
    localparam int IFS_FILT_MSB = 14;
    localparam int IFS_FSTOP_BIT = 15;
    localparam logic [31:0] IFS_CTRL_MASK = 32'h0000E000;
    localparam logic [31:0] IFS_CTRL_RESET = 32'h00000000;

    // ========================================================================
    // Field layout of the own-address register
    localparam int IFS_LOW_LSB = 0;
    localparam int IFS_LOW_MSB = 6;
    localparam int IFS_HIGH_LSB = 7;
    localparam int IFS_HIGH_MSB = 9;
    localparam int IFS_SETUP_LSB = 16;
    localparam int IFS_SETUP_MSB = 31;
    localparam logic [31:0] IFS_OWN_MASK = 32'hFFFF03FF;
    localparam logic [31:0] IFS_OWN_RESET = 32'h000F0055;

    // ========================================================================
    // Status register bits
    localparam int IFS_ST_SCL = 0;
    localparam int IFS_ST_SDA = 1;
    localparam int IFS_ST_STOP_BUSY = 2;
    localparam int IFS_ST_SYNC_BUSY = 3;

    // ========================================================================
    // Filter select codes and spike widths
    localparam logic [1:0] IFS_FILT_OFF = 2'h0;
    localparam logic [1:0] IFS_FILT_1 = 2'h1;
    localparam logic [1:0] IFS_FILT_2 = 2'h2;
    localparam logic [2:0] IFS_SPIKE_1 = 3'h1;
    localparam logic [2:0] IFS_SPIKE_2 = 3'h2;
    localparam logic [2:0] IFS_SPIKE_4 = 3'h4;

    // ========================================================================
    // Forced stop sequencer
    typedef enum logic [1:0] {
        IFS_STOP_IDLE = 2'b00,
        IFS_STOP_SDA_LOW = 2'b01,
        IFS_STOP_SCL_HIGH = 2'b11,
        IFS_STOP_SDA_HIGH = 2'b10
    } ifs_stop_state_t;

    localparam int IFS_STOP_HOLD_NS = 5000;
    localparam int IFS_KERNEL_MHZ = 8;

endpackage

// File: hdl/ifs_line_filter.sv
`timescale 1ns/1ps
// Spike filter for one bus line on the kernel clock
module ifs_line_filter
    import ifs_pkg::*;
(
    input wire logic kernel_clock,
    input wire logic reset_n,
    input wire logic line_in,
    input wire logic [1:0] filter_sel,
    output logic line_out
);

    logic sync1_q;
    logic sync2_q;
    logic out_q;
    logic [2:0] stable_q;
    logic [2:0] stable_d;
    logic [2:0] spike_len;
    logic differs;
    logic accept;

    // ========================================================================
    // Spike length per select code
    assign spike_len = (filter_sel == IFS_FILT_1) ? IFS_SPIKE_1 :
                       (filter_sel == IFS_FILT_2) ? IFS_SPIKE_2 : IFS_SPIKE_4;
    assign differs = (sync2_q != out_q);
    // New level taken when it outlasts the spike length, or at once with the filter off
    assign accept = (filter_sel == IFS_FILT_OFF) || (differs && stable_q >= spike_len);
    assign stable_d = (!differs || accept) ? 3'h0 :
                      (stable_q == IFS_SPIKE_4) ? stable_q : 3'(stable_q + 3'h1);
    assign line_out = out_q;

    // Two-stage synchroniser, then the filter state
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            out_q <= 1'b1;
            stable_q <= 3'h0;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            out_q <= accept ? sync2_q : out_q;
            stable_q <= stable_d;
        end
    end

endmodule // ifs_line_filter

// File: hdl/ifs_top.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
// Line filter, forced stop, own address and stretch setup of the two-wire controller
module ifs_top
    import ifs_pkg::*;
#(
    parameter int KERNEL_MHZ = IFS_KERNEL_MHZ
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic kernel_clock,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_filtered,
    output logic sda_filtered,
    input wire logic stretch_release,
    output logic setup_active,
    input wire logic [9:0] rx_addr,
    input wire logic rx_addr_10bit,
    input wire logic rx_addr_valid,
    output logic addr_match
);

    // Stop hold in kernel cycles, never below one so every step of the stop lasts
    // A slow kernel clock would otherwise round the hold to nothing
    localparam int STOP_HOLD_CYC_RAW = (IFS_STOP_HOLD_NS * KERNEL_MHZ) / 1000;
    localparam int STOP_HOLD_CYC = (STOP_HOLD_CYC_RAW < 1) ? 1 : STOP_HOLD_CYC_RAW;
    localparam logic [15:0] STOP_HOLD = 16'(STOP_HOLD_CYC);

    // ========================================================================
    // System-domain register file
    logic [31:0] ctrl_q;
    logic [31:0] own_q;
    logic ack_q;
    // Waitrequest kept in a flop of its own so the port comes from a register
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic req_tog_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic [2:0] st_s1_q;
    logic [2:0] st_s2_q;

    logic [31:0] be_mask;
    logic sel_ctrl;
    logic sel_own;
    logic sel_status;
    logic sync_busy;
    logic req_any;
    logic ack_d;
    logic wr_take;
    logic [31:0] ctrl_d;
    logic [31:0] own_d;
    logic [31:0] status_word;
    logic [31:0] rdata_d;

    // Byte-lane mask from byteenable
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_be
            assign be_mask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
        end
    endgenerate

    // Address decode and handshake state
    assign sel_ctrl = (avs_address == IFS_ADDR_CTRL);
    assign sel_own = (avs_address == IFS_ADDR_OWN);
    assign sel_status = (avs_address == IFS_ADDR_STATUS);
    // Writes wait while a copy is in flight, so the kernel never sees a half-changed word
    assign sync_busy = (req_tog_q != ack_s2_q);
    assign req_any = avs_read || (avs_write && !sync_busy);
    assign ack_d = req_any && !ack_q;
    assign wr_take = avs_write && ack_q;

    // Masked writes; reserved bits never stored
    assign ctrl_d = (wr_take && sel_ctrl) ?
        ((ctrl_q & ~be_mask) | (avs_writedata & be_mask)) & IFS_CTRL_MASK : ctrl_q;
    assign own_d = (wr_take && sel_own) ?
        ((own_q & ~be_mask) | (avs_writedata & be_mask)) & IFS_OWN_MASK : own_q;

    // Read mux; unmapped addresses read zero
    assign status_word = {28'h0, sync_busy, st_s2_q};
    assign rdata_d = sel_ctrl ? ctrl_q :
                     sel_own ? own_q :
                     sel_status ? status_word : 32'h0;

    // Bus answer: waitrequest drops for one cycle per request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            waitreq_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= ack_d;
            waitreq_q <= !ack_d;
            rdata_q <= ack_d ? rdata_d : rdata_q;
        end
    end

    // Registers and change toggle towards the kernel domain
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= IFS_CTRL_RESET;
            own_q <= IFS_OWN_RESET;
            req_tog_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            own_q <= own_d;
            req_tog_q <= (wr_take && (sel_ctrl || sel_own)) ? !req_tog_q : req_tog_q;
        end
    end

    // Acknowledge toggle and status levels back from the kernel domain
    logic ack_tog_q;
    logic [2:0] kstat;
    logic [2:0] kstat_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            st_s1_q <= 3'h3;
            st_s2_q <= 3'h3;
        end else begin
            ack_s1_q <= ack_tog_q;
            ack_s2_q <= ack_s1_q;
            st_s1_q <= kstat_q;
            st_s2_q <= st_s1_q;
        end
    end

    // Bus outputs straight from their flops
    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;

    // ========================================================================
    // Kernel-domain copy of the configuration
    logic req_s1_q;
    logic req_s2_q;
    logic [31:0] kctrl_q;
    logic [31:0] kown_q;
    logic take_cfg;

    // One-cycle capture strobe on each arriving toggle
    assign take_cfg = (req_s2_q != ack_tog_q);

    // Words are stable while the toggle is pending, so capture is safe
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_tog_q <= 1'b0;
            kctrl_q <= IFS_CTRL_RESET;
            kown_q <= IFS_OWN_RESET;
        end else begin
            req_s1_q <= req_tog_q;
            req_s2_q <= req_s1_q;
            ack_tog_q <= req_s2_q;
            kctrl_q <= take_cfg ? ctrl_q : kctrl_q;
            kown_q <= take_cfg ? own_q : kown_q;
        end
    end

    // ========================================================================
    // Line filters, one per bus line
    logic [1:0] raw_lines;
    logic [1:0] filt_lines;
    // Bit 0 is the clock line, bit 1 the data line
    assign raw_lines = {sda_in, scl_in};

    genvar gl;
    generate
        for (gl = 0; gl < 2; gl++) begin : g_filt
            ifs_line_filter u_filt (
                .kernel_clock(kernel_clock),
                .reset_n(reset_n),
                .line_in(raw_lines[gl]),
                .filter_sel(kctrl_q[IFS_FILT_MSB:IFS_FILT_LSB]),
                .line_out(filt_lines[gl])
            );
        end
    endgenerate

    // ========================================================================
    // Forced stop sequencer
    ifs_stop_state_t stop_q;
    ifs_stop_state_t stop_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic fstop_prev_q;
    logic fstop_rise;
    logic hold_done;
    logic scl_oe_n_q;
    logic sda_oe_n_q;

    // Start on the rise of the enable bit; hold counter done flag
    assign fstop_rise = kctrl_q[IFS_FSTOP_BIT] && !fstop_prev_q;
    assign hold_done = (hold_q == 16'h0);

    // SDA low with SCL low, release SCL, wait for SCL high, release SDA
    always_comb begin
        stop_d = stop_q;
        unique case (stop_q)
            IFS_STOP_IDLE: begin
                if (fstop_rise) begin
                    stop_d = IFS_STOP_SDA_LOW;
                end
            end
            IFS_STOP_SDA_LOW: begin
                if (hold_done) begin
                    stop_d = IFS_STOP_SCL_HIGH;
                end
            end
            IFS_STOP_SCL_HIGH: begin
                if (hold_done && filt_lines[0]) begin
                    stop_d = IFS_STOP_SDA_HIGH;
                end
            end
            IFS_STOP_SDA_HIGH: begin
                if (hold_done) begin
                    stop_d = IFS_STOP_IDLE;
                end
            end
        endcase
    end

    // Hold counter reloads on each state change
    // Clock-high wait counts only while the line is seen high, so stretching delays the stop
    assign hold_d = (stop_d != stop_q) ? STOP_HOLD :
                    (!hold_done && !(stop_q == IFS_STOP_SCL_HIGH && !filt_lines[0])) ?
                    16'(hold_q - 16'h1) : hold_q;

    // Sequencer state, hold count and enable history
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            stop_q <= IFS_STOP_IDLE;
            hold_q <= 16'h0;
            fstop_prev_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
            hold_q <= hold_d;
            fstop_prev_q <= kctrl_q[IFS_FSTOP_BIT];
        end
    end

    // Open-drain drivers: enable low means pulling the line low
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= (stop_d != IFS_STOP_SDA_LOW);
            sda_oe_n_q <= (stop_d != IFS_STOP_SDA_LOW) && (stop_d != IFS_STOP_SCL_HIGH);
        end
    end

    // Lines only ever pulled low; enables from flops
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;

    // ========================================================================
    // Setup delay after stretch release
    logic [15:0] setup_q;
    logic [15:0] setup_field;
    logic [15:0] setup_d;
    logic setup_act_q;

    // Setup field from the kernel copy
    assign setup_field = kown_q[IFS_SETUP_MSB:IFS_SETUP_LSB];
    // Field minus one cycles; 0 or 1 give no delay
    assign setup_d = (stretch_release && setup_field > 16'h1) ? 16'(setup_field - 16'h1) :
                     (setup_q != 16'h0) ? 16'(setup_q - 16'h1) : setup_q;

    // Setup countdown and its window flag
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            setup_q <= 16'h0;
            setup_act_q <= 1'b0;
        end else begin
            setup_q <= setup_d;
            setup_act_q <= (setup_d != 16'h0);
        end
    end

    // Setup window straight from its flop
    assign setup_active = setup_act_q;

    // ========================================================================
    // Own-address match
    logic [9:0] own_full;
    logic match_hit;
    logic match_q;
    logic scl_f_q;
    logic sda_f_q;

    // Address to match; short mode keeps the high bits zero so stray high bits miss
    assign own_full = rx_addr_10bit ?
        {kown_q[IFS_HIGH_MSB:IFS_HIGH_LSB], kown_q[IFS_LOW_MSB:IFS_LOW_LSB]} :
        {3'h0, kown_q[IFS_LOW_MSB:IFS_LOW_LSB]};
    assign match_hit = rx_addr_valid && (rx_addr == own_full);

    // Match result and filtered line levels
    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            match_q <= 1'b0;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            match_q <= match_hit;
            scl_f_q <= filt_lines[0];
            sda_f_q <= filt_lines[1];
        end
    end

    // Match and filtered lines straight from flops
    assign addr_match = match_q;
    assign scl_filtered = scl_f_q;
    assign sda_filtered = sda_f_q;

    // ========================================================================
    // Status towards the system domain
    // Registered first so no glitch of the decode reaches the synchroniser
    assign kstat = {stop_q != IFS_STOP_IDLE, filt_lines[1], filt_lines[0]};

    always_ff @(posedge kernel_clock or negedge reset_n) begin
        if (!reset_n) begin
            kstat_q <= 3'h3;
        end else begin
            kstat_q <= kstat;
        end
    end

endmodule // ifs_top

// File: testbench/ifs_top_chk.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the filter, stop and own-address block
module ifs_top_chk
    import ifs_pkg::*;
#(
    parameter int KERNEL_MHZ = IFS_KERNEL_MHZ
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic kernel_clock,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic stretch_release,
    input wire logic setup_active,
    input wire logic [9:0] rx_addr,
    input wire logic rx_addr_10bit,
    input wire logic rx_addr_valid,
    input wire logic addr_match
);
    // ============================================================
    // Register bus
    a_ack_one_cycle: assert property (@(posedge clock) disable iff (!reset_n)
        !avs_waitrequest |=> avs_waitrequest) else $error("ack longer than one cycle");
    a_ack_has_request: assert property (@(posedge clock) disable iff (!reset_n)
        !avs_waitrequest |-> $past(avs_read || avs_write)) else $error("ack without request");
    a_own_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
        avs_read && !avs_waitrequest && avs_address == 4'h4 |-> avs_readdata[15:10] == 6'h0)
        else $error("own register reserved bits set");
    a_ctrl_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
        avs_read && !avs_waitrequest && avs_address == 4'h0 |-> (avs_readdata & 32'hFFFF1FFF) == 0)
        else $error("control register reserved bits set");
    a_unmapped_reads_zero: assert property (@(posedge clock) disable iff (!reset_n)
        avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == 32'h0)
        else $error("unmapped address not zero");
    // ============================================================
    // Bus lines and kernel side
    a_open_drain_only: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        !scl_out && !sda_out) else $error("line driven high");
    a_stop_scl_first: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        $rose(scl_oe_n) |-> !sda_oe_n) else $error("clock released with data free");
    a_stop_sda_last: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        $rose(sda_oe_n) |-> scl_oe_n) else $error("data released with clock low");
    a_match_has_valid: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        addr_match |-> $past(rx_addr_valid)) else $error("match without valid");
    a_match_7bit_high: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        rx_addr_valid && !rx_addr_10bit && rx_addr[9:7] != 3'h0 |=> !addr_match)
        else $error("short address matched with high bits");
    a_setup_has_release: assert property (@(posedge kernel_clock) disable iff (!reset_n)
        $rose(setup_active) |-> $past(stretch_release)) else $error("setup without release");
endmodule // ifs_top_chk

bind ifs_top ifs_top_chk #(.KERNEL_MHZ(KERNEL_MHZ)) i_ifs_top_chk (.*);

// File: testbench/ifs_bus_peer.sv
`timescale 1ns/1ps
// ============================================================
// Other party on the two-wire bus, with pull-ups on both lines
module ifs_bus_peer (
    input wire logic kernel_clock,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    output logic scl_line,
    output logic sda_line
);
    logic pull_q = 1'b0;
    // Wired-and of both parties on data, clock from the controller alone; pulled up when free
    assign scl_line = scl_oe_n;
    assign sda_line = sda_oe_n & !pull_q;
    // Pull data low for w kernel cycles
    task automatic spike(input int w);
        @(posedge kernel_clock) pull_q <= 1'b1;
        repeat (w) @(posedge kernel_clock);
        pull_q <= 1'b0;
    endtask
endmodule // ifs_bus_peer

// File: testbench/ifs_top_bench.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench
module ifs_top_bench;
    import ifs_pkg::*;
    logic clock = 1'b0;
    logic kernel_clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic scl_filtered, sda_filtered, scl_line, sda_line, setup_active, addr_match;
    logic stretch_release = 1'b0;
    logic [9:0] rx_addr = 10'h0;
    logic rx_addr_10bit = 1'b0;
    logic rx_addr_valid = 1'b0;
    logic [1:0] codes [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int widths [5] = '{1, 1, 2, 4, 8};
    logic passes [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    int fail_count = 0;
    int checks = 0;
    int lows = 0;
    int highs = 0;
    int stops = 0;
    int slows = 0;

    // Clocks, kernel clock offset in phase
    always #10 clock = ~clock;
    initial begin
        #7;
        forever #62.5 kernel_clock = ~kernel_clock;
    end

    ifs_top #(.KERNEL_MHZ(1)) i_ifs_top (.*, .avs_byteenable(4'hF), .scl_in(scl_line),
        .sda_in(sda_line));
    ifs_bus_peer i_ifs_bus_peer (.*);

    // Monitors of both filtered lines, setup window and STOP edges
    always @(posedge kernel_clock) begin
        if (sda_filtered === 1'b0) lows++;
        if (scl_filtered === 1'b0) slows++;
        if (setup_active === 1'b1) highs++;
    end
    always @(posedge sda_line) if (scl_line === 1'b1) stops++;

    task automatic finish_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 400);
        if (n >= 400) fail_count++;
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic kwait(input int n);
        repeat (n) @(posedge kernel_clock);
        @(posedge clock);
    endtask

    task automatic match(input logic [9:0] a, input logic ten, input logic exp);
        @(posedge kernel_clock);
        rx_addr <= a;
        rx_addr_10bit <= ten;
        rx_addr_valid <= 1'b1;
        @(posedge kernel_clock) rx_addr_valid <= 1'b0;
        @(posedge kernel_clock);
        chk({31'h0, addr_match}, {31'h0, exp});
        @(posedge clock);
    endtask

    task automatic setup(input int exp);
        highs = 0;
        @(posedge kernel_clock) stretch_release <= 1'b1;
        @(posedge kernel_clock) stretch_release <= 1'b0;
        kwait(20);
        chk(highs, exp);
    endtask

    task automatic own(input logic [31:0] d);
        bus(1'b1, IFS_ADDR_OWN, d, q);
        kwait(8);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        bus(1'b1, IFS_ADDR_OWN, IFS_OWN_RESET, q);
        bus(1'b0, IFS_ADDR_STATUS, 32'h0, q);
        chk(q, 32'h0000000B);
        bus(1'b0, IFS_ADDR_OWN, 32'h0, q);
        chk(q, 32'h000F0055);
        bus(1'b0, IFS_ADDR_CTRL, 32'h0, q);
        chk(q, 32'h0);
        match(10'h055, 1'b0, 1'b1);
        match(10'h055, 1'b1, 1'b1);
        setup(14);
        bus(1'b0, IFS_ADDR_STATUS, 32'h0, q);
        chk(q, 32'h00000003);
        bus(1'b1, IFS_ADDR_CTRL, 32'hFFFFFFFF, q);
        bus(1'b0, IFS_ADDR_CTRL, 32'h0, q);
        chk(q, 32'h0000E000);
        bus(1'b1, IFS_ADDR_OWN, 32'hFFFFFFFF, q);
        bus(1'b0, IFS_ADDR_OWN, 32'h0, q);
        chk(q, 32'hFFFF03FF);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
        bus(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
        own(32'h000302AA);
        match(10'h2AA, 1'b1, 1'b1);
        match(10'h02A, 1'b0, 1'b1);
        match(10'h02A, 1'b1, 1'b0);
        match(10'h02B, 1'b0, 1'b0);
        match(10'h0AA, 1'b0, 1'b0);
        setup(2);
        own(32'h000502AA);
        setup(4);
        own(32'h000102AA);
        setup(0);
        // Forced stop on each rise of the enable bit only
        bus(1'b1, IFS_ADDR_CTRL, 32'h0, q);
        kwait(60);
        stops = 0;
        slows = 0;
        bus(1'b1, IFS_ADDR_CTRL, 32'h00008000, q);
        kwait(60);
        chk(stops, 1);
        chk({31'h0, slows != 0}, 32'h1);
        bus(1'b1, IFS_ADDR_CTRL, 32'h00008000, q);
        kwait(60);
        chk(stops, 1);
        bus(1'b1, IFS_ADDR_CTRL, 32'h0, q);
        bus(1'b1, IFS_ADDR_CTRL, 32'h00008000, q);
        kwait(60);
        chk(stops, 2);
        // Spikes against every filter code
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, IFS_ADDR_CTRL, {17'h0, codes[i], 13'h0}, q);
            kwait(10);
            lows = 0;
            i_ifs_bus_peer.spike(widths[i]);
            kwait(12);
            chk({31'h0, lows != 0}, {31'h0, passes[i]});
        end
        finish_test;
    end

    // Watchdog
    initial begin
        #1000000;
        fail_count++;
        finish_test;
    end
endmodule // ifs_top_bench
